// File: verilog/card_fmt_defs.vh
// Constants for the stripe card output formatter
`ifndef CARD_FMT_DEFS_VH
`define CARD_FMT_DEFS_VH
`define CLK_MHZ 250
`define DLY_BASE_MS 7'd2
`define DLY_STEP_MS 2
`define DLY_MAX_SET 6'h20
`define CYC_PER_MS (`CLK_MHZ * 1000)
`define CHR_MIN 8'h20
`define CHR_MAX 8'h7E
`define CHR_CR 8'h0D
`define DEF_LEAD1 8'h25
`define DEF_LEAD23 8'h3B
`define DEF_END 8'h3F
`define DEF_DLY_EN 6'h00
`define DEF_DLY_NE 6'h04
`define DEF_ALT_EN 1'b0
`define DEF_ALT_NE 1'b1
`define KEY_ALT 8'h80
`define KEY_PAD0 8'h90
`endif

// File: verilog/sync_fifo.v
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ns
`default_nettype none
module sync_fifo #(
   parameter WIDTH = 10,
   parameter DEPTH = 8,
   parameter AW = 3
) (
   input wire clk_i,
   input wire reset_n_i,
   input wire [WIDTH-1:0] in_data_i,
   input wire in_valid_i,
   output wire in_ready_o,
   output wire [WIDTH-1:0] out_data_o,
   output wire out_valid_o,
   input wire out_ready_i
);
   reg [WIDTH-1:0] mem [0:DEPTH-1]; // Storage
   reg [AW-1:0] wr_r; // Write pointer
   reg [AW-1:0] rd_r; // Read pointer
   reg [AW:0] cnt_r; // Fill level
   wire push = in_valid_i && in_ready_o;
   wire pop = out_valid_o && out_ready_i;
   assign in_ready_o = (cnt_r != DEPTH[AW:0]);
   assign out_valid_o = (cnt_r != {(AW+1){1'b0}});
   assign out_data_o = mem[rd_r];
   // Memory write, no reset needed for data
   always @(posedge clk_i) begin
      if (push) begin
         mem[wr_r] <= in_data_i;
      end
   end
   // Pointers and level
   always @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         wr_r <= {AW{1'b0}};
         rd_r <= {AW{1'b0}};
         cnt_r <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_r <= (wr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_r + 1'b1;
         end
         if (pop) begin
            rd_r <= (rd_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_r + 1'b1;
         end
         if (push && !pop) begin
            cnt_r <= cnt_r + 1'b1;
         end else if (pop && !push) begin
            cnt_r <= cnt_r - 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// File: verilog/stripe_card_output_formatter.v
// Stripe card track formatter emitting keyboard key events
// Functional notes
// (R1) Card data leaves as keyboard key events
// (R2) Alt-keypad digits for letters when enabled
// (R3) Alt-keypad no effect on digit tracks
// (R4) Append check character when enabled
// (R5) Extra carriage return after ending code
// (R6) Programmable delay between characters, 0..32
// (R7) Delay is 2 ms plus 2 ms per step
// (R8) Track sent only if enabled and head present
// (R9) Sentinels off: always end track with CR
// (R10) Framing codes limited to 20h..7Eh
// (R11) Defaults percent, semicolon, question mark
// (R12) Two default sets, English and non-English
// (R13) Order: lead, data, end, check, CR
`timescale 1ns/1ns
`default_nettype none
`include "card_fmt_defs.vh"
module stripe_card_output_formatter #(
   parameter CYC_PER_MS = `CYC_PER_MS,
   parameter DEPTH = 8
) (
   input wire clk_i,
   input wire reset_n_i,
   input wire [7:0] trk_data_i,
   input wire [1:0] trk_id_i,
   input wire trk_valid_i,
   input wire trk_last_i,
   output wire trk_ready_o,
   input wire [2:0] trk_enable_i,
   input wire [2:0] head_present_i,
   input wire alt_num_en_i,
   input wire send_lrc_i,
   input wire extra_cr_i,
   input wire send_sentinel_i,
   input wire [5:0] delay_set_i,
   input wire [7:0] lead1_i,
   input wire [7:0] lead2_i,
   input wire [7:0] lead3_i,
   input wire [7:0] end_code_i,
   input wire cfg_write_i,
   input wire reset_english_i,
   input wire reset_non_english_i,
   output reg [7:0] key_code_o,
   output reg key_valid_o,
   input wire key_ready_i,
   output wire [2:0] active_cfg_en_o,
   output wire [5:0] active_delay_o,
   output wire active_alt_o
);
   localparam S_IDLE = 3'h0;
   localparam S_LEAD = 3'h1;
   localparam S_DATA = 3'h2;
   localparam S_END = 3'h3;
   localparam S_LRC = 3'h4;
   localparam S_CR = 3'h5;
   // Option registers, loaded by cfg_write or default commands
   reg [2:0] en_r;
   reg alt_r, lrc_r, cr_r, sen_r;
   reg [5:0] dly_r;
   reg [7:0] lead1_r, lead2_r, lead3_r, end_r;
   reg [2:0] st_r; // Framer state
   reg [1:0] trk_r; // Track being framed
   reg [7:0] lrc_acc_r; // Running XOR check
   wire [9:0] fifo_din; // {always 0, char-is-data, code}
   reg [9:0] fifo_din_r;
   reg fifo_wv;
   wire fifo_wr;
   wire [9:0] fifo_dout;
   wire fifo_ov;
   reg fifo_rd;
   assign active_cfg_en_o = en_r;
   assign active_delay_o = dly_r;
   assign active_alt_o = alt_r;
   // Printable range check for framing codes
   function [7:0] clamp;
      input [7:0] c;
      input [7:0] d;
      begin
         clamp = (c >= `CHR_MIN && c <= `CHR_MAX) ? c : d; // (R10)
      end
   endfunction
   // Configuration; default commands win over an ordinary write
   always @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         en_r <= 3'h7;
         alt_r <= `DEF_ALT_EN;
         lrc_r <= 1'b0;
         cr_r <= 1'b0;
         sen_r <= 1'b1;
         dly_r <= `DEF_DLY_EN;
         lead1_r <= `DEF_LEAD1; // (R11)
         lead2_r <= `DEF_LEAD23;
         lead3_r <= `DEF_LEAD23;
         end_r <= `DEF_END;
      end else if (reset_english_i || reset_non_english_i) begin
         en_r <= 3'h7; // (R12)
         alt_r <= reset_english_i ? `DEF_ALT_EN : `DEF_ALT_NE;
         dly_r <= reset_english_i ? `DEF_DLY_EN : `DEF_DLY_NE;
         lrc_r <= 1'b0;
         cr_r <= 1'b0;
         sen_r <= 1'b1;
         lead1_r <= `DEF_LEAD1; // (R11)
         lead2_r <= `DEF_LEAD23;
         lead3_r <= `DEF_LEAD23;
         end_r <= `DEF_END;
      end else if (cfg_write_i) begin
         en_r <= trk_enable_i;
         alt_r <= alt_num_en_i;
         lrc_r <= send_lrc_i;
         cr_r <= extra_cr_i;
         sen_r <= send_sentinel_i;
         dly_r <= (delay_set_i > `DLY_MAX_SET) ? `DLY_MAX_SET : delay_set_i; // (R6)
         lead1_r <= clamp(lead1_i, `DEF_LEAD1);
         lead2_r <= clamp(lead2_i, `DEF_LEAD23);
         lead3_r <= clamp(lead3_i, `DEF_LEAD23);
         end_r <= clamp(end_code_i, `DEF_END);
      end
   end
   // Track passes only when enabled and its head exists
   wire trk_ok = en_r[trk_id_i] && head_present_i[trk_id_i]; // (R8)
   wire [7:0] lead_sel = (trk_r == 2'd0) ? lead1_r : (trk_r == 2'd1) ? lead2_r : lead3_r;
   wire fifo_ir;
   // Framer: consumes raw track bytes, produces framed characters
   always @* begin
      fifo_wv = 1'b0;
      fifo_din_r = 10'h000;
      case (st_r)
         S_LEAD: begin
            fifo_wv = 1'b1;
            fifo_din_r = {2'b00, lead_sel}; // (R13)
         end
         S_DATA: begin
            fifo_wv = trk_valid_i;
            fifo_din_r = {2'b01, trk_data_i};
         end
         S_END: begin
            fifo_wv = 1'b1;
            fifo_din_r = {2'b00, end_r};
         end
         S_LRC: begin
            fifo_wv = 1'b1;
            fifo_din_r = {2'b00, lrc_acc_r}; // (R4)
         end
         S_CR: begin
            fifo_wv = 1'b1;
            fifo_din_r = {2'b00, `CHR_CR};
         end
         default: begin
            fifo_wv = 1'b0;
         end
      endcase
   end
   assign fifo_din = fifo_din_r;
   assign fifo_wr = fifo_wv && fifo_ir;
   // Raw data accepted in DATA state when FIFO has room; dropped tracks accepted only while IDLE
   assign trk_ready_o = (st_r == S_DATA) ? fifo_ir : (st_r == S_IDLE && !trk_ok);
   wire need_cr = sen_r ? cr_r : 1'b1; // (R9) (R5)
   always @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         st_r <= S_IDLE;
         trk_r <= 2'd0;
         lrc_acc_r <= 8'h00;
      end else begin
         case (st_r)
            S_IDLE: begin
               if (trk_valid_i && trk_ok) begin
                  trk_r <= trk_id_i;
                  lrc_acc_r <= 8'h00;
                  st_r <= sen_r ? S_LEAD : S_DATA;
               end
            end
            S_LEAD: begin
               if (fifo_ir) begin
                  lrc_acc_r <= lead_sel;
                  st_r <= S_DATA;
               end
            end
            S_DATA: begin
               if (fifo_wr) begin
                  lrc_acc_r <= lrc_acc_r ^ trk_data_i;
                  if (trk_last_i) begin
                     st_r <= sen_r ? S_END : (lrc_r ? S_LRC : S_CR);
                  end
               end
            end
            S_END: begin
               if (fifo_ir) begin
                  lrc_acc_r <= lrc_acc_r ^ end_r;
                  st_r <= lrc_r ? S_LRC : (need_cr ? S_CR : S_IDLE);
               end
            end
            S_LRC: begin
               if (fifo_ir) begin
                  st_r <= need_cr ? S_CR : S_IDLE;
               end
            end
            S_CR: begin
               if (fifo_ir) begin
                  st_r <= S_IDLE;
               end
            end
            default: begin
               st_r <= S_IDLE;
            end
         endcase
      end
   end
   // Framed characters wait here so the card side can run ahead of pacing
   sync_fifo #(.WIDTH(10), .DEPTH(DEPTH), .AW(3)) u_fifo (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .in_data_i(fifo_din),
      .in_valid_i(fifo_wv),
      .in_ready_o(fifo_ir),
      .out_data_o(fifo_dout),
      .out_valid_o(fifo_ov),
      .out_ready_i(fifo_rd)
   );
   // Pacing: millisecond tick and gap counter
   reg [17:0] ms_cnt_r;
   reg [6:0] gap_r; // Remaining ms of gap
   wire ms_tick = (ms_cnt_r == CYC_PER_MS[17:0] - 18'd1);
   // Key emitter: letters become Alt + keypad digits
   reg [2:0] ks_r; // 0 idle,1 alt,2 hund,3 tens,4 ones
   reg [7:0] ch_r;
   wire [7:0] ch = fifo_dout[7:0];
   wire is_alpha = fifo_dout[8] && ((ch >= 8'h41 && ch <= 8'h5A) || (ch >= 8'h61 && ch <= 8'h7A));
   wire [7:0] hund = ch_r / 8'd100;
   wire [7:0] tens = (ch_r / 8'd10) % 8'd10;
   wire [7:0] ones = ch_r % 8'd10;
   wire gap_done = (gap_r == 7'd0);
   wire key_take = key_valid_o && key_ready_i;
   always @* begin
      fifo_rd = 1'b0;
      if (!key_valid_o && gap_done && ks_r == 3'd0 && fifo_ov) begin
         fifo_rd = 1'b1;
      end
   end
   always @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ms_cnt_r <= 18'd0;
         gap_r <= 7'd0;
         ks_r <= 3'd0;
         ch_r <= 8'h00;
         key_code_o <= 8'h00;
         key_valid_o <= 1'b0;
      end else begin
         ms_cnt_r <= ms_tick ? 18'd0 : ms_cnt_r + 18'd1;
         if (ms_tick && !gap_done) begin
            gap_r <= gap_r - 7'd1; // (R6)
         end
         if (key_take) begin
            key_valid_o <= 1'b0;
            if (ks_r == 3'd0 || ks_r == 3'd4) begin
               ks_r <= 3'd0;
               gap_r <= `DLY_BASE_MS + {dly_r, 1'b0}; // (R7)
            end else if (ks_r == 3'd1 && hund == 8'h00) begin
               // Codes below 100 go out as two digits; a leading zero would pick another code page
               ks_r <= 3'd3;
               key_valid_o <= 1'b1;
               key_code_o <= `KEY_PAD0 + tens; // (R2)
            end else begin
               ks_r <= ks_r + 3'd1;
               key_valid_o <= 1'b1;
               key_code_o <= `KEY_PAD0 + ((ks_r == 3'd1) ? hund : (ks_r == 3'd2) ? tens : ones); // (R2)
            end
         end else if (fifo_rd) begin
            key_valid_o <= 1'b1; // (R1)
            ch_r <= ch;
            if (alt_r && is_alpha) begin
               ks_r <= 3'd1;
               key_code_o <= `KEY_ALT; // (R2) (R3)
            end else begin
               key_code_o <= ch;
            end
         end
      end
   end
endmodule
`default_nettype wire

// File: tb/fmt_chk_sva.sv
// Assertions on the formatter key output and option registers
`timescale 1ns/1ns
`default_nettype none
module fmt_chk #(parameter CYC_PER_MS = 10) (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic cfg_write_i,
   input wire logic reset_english_i,
   input wire logic reset_non_english_i,
   input wire logic alt_num_en_i,
   input wire logic [2:0] trk_enable_i,
   input wire logic [5:0] delay_set_i,
   input wire logic [7:0] key_code_o,
   input wire logic key_valid_o,
   input wire logic key_ready_i,
   input wire logic [2:0] active_cfg_en_o,
   input wire logic [5:0] active_delay_o,
   input wire logic active_alt_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);
   // Cycles since the last accepted key, saturating
   logic [31:0] gap_r; // Wide enough for the longest gap at the real clock rate
   // Last key was plain; Alt groups are paced as one unit
   logic plain_r;
   // Plain config load, no default reset in the same cycle
   wire load = cfg_write_i && !reset_english_i && !reset_non_english_i;
   // Track the idle time between accepted keys
   always @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         gap_r <= 32'h00000000;
         plain_r <= 1'b0;
      end else if (key_valid_o && key_ready_i) begin
         gap_r <= 32'h00000000;
         plain_r <= key_code_o < 8'h80;
      end else if (gap_r != 32'hFFFFFFFF) begin
         gap_r <= gap_r + 32'h00000001;
      end
   end
   a_key_holds: assert property (key_valid_o && !key_ready_i |=> key_valid_o)
      else $error("key dropped before host took it");
   a_code_stable: assert property (key_valid_o && !key_ready_i |=> $stable(key_code_o))
      else $error("key code changed while waiting");
   a_delay_range: assert property (active_delay_o <= 6'h20)
      else $error("delay setting above 32");
   a_eng_dflt: assert property (reset_english_i |=>
      !active_alt_o && active_delay_o == 6'h00 && active_cfg_en_o == 3'h7) else $error("english defaults wrong");
   a_ne_dflt: assert property (reset_non_english_i && !reset_english_i |=>
      active_alt_o && active_delay_o == 6'h04) else $error("non-english defaults wrong");
   a_cfg_load: assert property (load |=> active_cfg_en_o == $past(trk_enable_i) &&
      active_alt_o == $past(alt_num_en_i)) else $error("options not loaded");
   a_delay_clamp: assert property (load |=>
      active_delay_o == ($past(delay_set_i) > 6'h20 ? 6'h20 : $past(delay_set_i))) else $error("delay not clamped");
   a_char_gap: assert property ($rose(key_valid_o) && plain_r |->
      gap_r >= (1 + 2 * active_delay_o) * CYC_PER_MS) else $error("character gap too short");
endmodule
bind stripe_card_output_formatter fmt_chk #(.CYC_PER_MS(CYC_PER_MS)) chk (.clk_i(clk_i), .reset_n_i(reset_n_i),
   .cfg_write_i(cfg_write_i), .reset_english_i(reset_english_i), .reset_non_english_i(reset_non_english_i),
   .alt_num_en_i(alt_num_en_i), .trk_enable_i(trk_enable_i), .delay_set_i(delay_set_i), .key_code_o(key_code_o),
   .key_valid_o(key_valid_o), .key_ready_i(key_ready_i), .active_cfg_en_o(active_cfg_en_o),
   .active_delay_o(active_delay_o), .active_alt_o(active_alt_o));
`default_nettype wire

// File: tb/key_host.sv
// Host model taking key events, promptly or with stalls
`timescale 1ns/1ns
`default_nettype none
module key_host (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic [7:0] code_i,
   input wire logic valid_i,
   input wire logic slow_i,
   output logic ready_o
);
   // Keys received, oldest first
   logic [7:0] got[$];
   // Stall phase; slow host takes one key in four cycles
   logic [1:0] cnt_r;
   always @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         cnt_r <= 2'h0;
      end else begin
         cnt_r <= cnt_r + 2'h1;
      end
   end
   assign ready_o = !slow_i || cnt_r == 2'h3;
   // Record each key as if typed
   always @(posedge clk_i) begin
      if (reset_n_i && valid_i && ready_o) begin
         got.push_back(code_i);
      end
   end
endmodule
`default_nettype wire

// File: tb/stripe_card_output_formatter_tb.sv
// Testbench for the stripe card output formatter
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin n_fail++; $display("mismatch t=%0t got=%h exp=%h", $time, a, e); end end
module stripe_card_output_formatter_tb;
   logic clk_i = 0, reset_n_i = 0, tv = 0, tl = 0, lrc = 0, cr = 0, alt = 0, snt = 1, cw = 0, re = 0, rn = 0;
   logic slow = 0, rdy, kv, alt_o, full_seen = 0;
   logic [7:0] td = 8'h00, l1 = 8'h25, kc;
   logic [7:0] l2 = 8'h3B, l3 = 8'h3B, ec = 8'h3F;
   logic [1:0] tid = 2'h0;
   logic [2:0] en = 3'h7, head = 3'h7, en_o;
   logic [5:0] dly = 6'h00, dly_o;
   logic [7:0] exp[$];
   int n_fail = 0, samples_checked = 0;
   wire kr;
   stripe_card_output_formatter #(.CYC_PER_MS(10), .DEPTH(8)) uut (.clk_i(clk_i), .reset_n_i(reset_n_i),
      .trk_data_i(td), .trk_id_i(tid), .trk_valid_i(tv), .trk_last_i(tl), .trk_ready_o(rdy), .trk_enable_i(en),
      .head_present_i(head), .alt_num_en_i(alt), .send_lrc_i(lrc), .extra_cr_i(cr), .send_sentinel_i(snt),
      .delay_set_i(dly), .lead1_i(l1), .lead2_i(l2), .lead3_i(l3), .end_code_i(ec), .cfg_write_i(cw),
      .reset_english_i(re), .reset_non_english_i(rn), .key_code_o(kc), .key_valid_o(kv), .key_ready_i(kr),
      .active_cfg_en_o(en_o), .active_delay_o(dly_o), .active_alt_o(alt_o));
   key_host host (.clk_i(clk_i), .reset_n_i(reset_n_i), .code_i(kc), .valid_i(kv), .slow_i(slow), .ready_o(kr));
   // 250 MHz clock
   initial begin
      forever #2 clk_i = ~clk_i;
   end
   // Send one track, holding each byte until taken
   task automatic track(input logic [1:0] t, input string s);
      for (int i = 0; i < s.len(); i++) begin
         tid <= t;
         td <= s[i];
         tl <= (i == s.len() - 1);
         tv <= 1'b1;
         @(posedge clk_i);
         while (rdy !== 1'b1) begin
            full_seen = 1'b1;
            @(posedge clk_i);
         end
      end
      tv <= 1'b0;
      // One idle edge so a following track never re-raises valid in the same step
      @(posedge clk_i);
   endtask
   // Load options with a one-cycle write pulse
   task automatic cfg(input logic [2:0] e, input logic s, c, r, a, input logic [5:0] d, input logic [7:0] l);
      {en, snt, lrc, cr, alt, dly, l1, cw} <= {e, s, c, r, a, d, l, 1'b1};
      @(posedge clk_i);
      cw <= 1'b0;
      @(posedge clk_i);
   endtask
   // Queue expected text
   task automatic add(input string s);
      foreach (s[i]) exp.push_back(s[i]);
   endtask
   // Wait for the keys, allow extras to show, compare all
   task automatic check_keys();
      for (int i = 0; i < 20000 && host.got.size() < exp.size(); i++) @(posedge clk_i);
      repeat (800) @(posedge clk_i);
      `CHK(host.got.size(), exp.size())
      foreach (exp[i]) `CHK(host.got[i], exp[i])
      host.got.delete();
      exp.delete();
   endtask
   task automatic stop_test();
      $display("checked=%0d failed=%0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // Cut a hang short
   initial begin
      #300000;
      n_fail++;
      stop_test();
   end
   initial begin
      repeat (4) @(posedge clk_i);
      reset_n_i <= 1'b1;
      @(posedge clk_i);
      // Defaults, slow host so the FIFO fills and stalls the track input
      slow <= 1'b1;
      track(2'h1, "0123456789");
      add(";0123456789?");
      check_keys();
      `CHK(full_seen, 1'b1)
      slow <= 1'b0;
      // Custom lead, Alt groups for two- and three-digit letters, check char and CR
      cfg(3'h7, 1, 1, 1, 1, 6'h02, 8'h23);
      track(2'h0, "Az1");
      add("#");
      exp.push_back(8'h80); exp.push_back(8'h96); exp.push_back(8'h95);
      exp.push_back(8'h80);
      exp.push_back(8'h91);
      exp.push_back(8'h92);
      exp.push_back(8'h92);
      add("1?");
      exp.push_back(8'h16); exp.push_back(8'h0D);
      check_keys();
      // No sentinels, track 1 off, head 3 absent, delay clamped
      head <= 3'b011;
      cfg(3'h6, 0, 1, 0, 1, 6'h28, 8'h25);
      `CHK(dly_o, 6'h20)
      track(2'h0, "Z");
      track(2'h2, "9");
      track(2'h1, "5");
      add("5");
      exp.push_back(8'h35);
      exp.push_back(8'h0D);
      check_keys();
      head <= 3'h7;
      // Default sets
      rn <= 1'b1;
      @(posedge clk_i);
      rn <= 1'b0;
      @(posedge clk_i);
      `CHK({alt_o, dly_o}, {1'b1, 6'h04})
      re <= 1'b1;
      @(posedge clk_i);
      re <= 1'b0;
      @(posedge clk_i);
      `CHK({alt_o, dly_o, en_o}, {1'b0, 6'h00, 3'h7})
      // Out-of-range codes fall back to defaults, in-range ones are taken
      l2 <= 8'h1F;
      l3 <= 8'h40;
      ec <= 8'h2A;
      cfg(3'h7, 1, 0, 0, 0, 6'h00, 8'h7F);
      track(2'h0, "B");
      track(2'h1, "7");
      track(2'h2, "8");
      add("%B*;7*@8*");
      check_keys();
      stop_test();
   end
endmodule
`default_nettype wire
